// File: design/clk_switch_pkg.sv
package clk_switch_pkg;
   // selection widths
   localparam int SRC_W = 3;
   localparam int DIV_W = 4;
   // reset values of the request and status fields
   localparam logic [2:0] SRC_RESET = 3'h0;
   localparam logic [3:0] DIV_RESET = 4'h0;
   // source codes that run through the loop, each with its own loop input
   localparam logic [2:0] SRC_LOOP_HF = 3'h1;
   localparam logic [2:0] SRC_LOOP_EXT = 3'h2;
   // loop lock timing at a 5 ns clock; longest wait rounds down
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LOCK_TIMEOUT_NS = 2000;
   localparam int LOCK_TIMEOUT_CYC = (LOCK_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int LOCK_CNT_W = 12;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_OSC,
      ST_READY,
      ST_LOCK,
      ST_SLEEP
   } switch_state_t;

   // true when a source selection is fed through the loop
   function automatic logic is_loop(input logic [2:0] sel);
      is_loop = (sel == SRC_LOOP_HF) || (sel == SRC_LOOP_EXT);
   endfunction : is_loop
endpackage : clk_switch_pkg

// File: design/lock_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lock_timer_if;
   logic run;
   logic expired;
   modport owner (output run, input expired);
   modport timer (input run, output expired);
endinterface : lock_timer_if
`default_nettype wire

// File: design/lock_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lock_timer #(
   parameter int COUNT = clk_switch_pkg::LOCK_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // run and expiry
   lock_timer_if.timer tmr
);
   import clk_switch_pkg::*;

   localparam logic [LOCK_CNT_W-1:0] LAST = LOCK_CNT_W'(COUNT - 1);
   logic [LOCK_CNT_W-1:0] count;

   // counts while run is high, restarts whenever run drops
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else if (!tmr.run) begin
         count <= '0;
      end else if (count != LAST) begin
         count <= count + 1'b1;
      end
   end

   // one-cycle expiry pulse on reaching the last count
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tmr.expired <= 1'b0;
      end else begin
         tmr.expired <= tmr.run && (count == LAST - 1'b1);
      end
   end
endmodule : lock_timer
`default_nettype wire

// File: design/clock_switch_sequencer.sv
// What this block does
// - divider-only change goes from idle straight to ready
// - divider-only change skips oscillator start-up wait
// - no switch completes while hold is set, except a loop switch already waiting for lock
// - status keeps old selection until the switch
// - switch loads status and sets ready flag
// - hardware clears new-source-ready on completion
// - loop input follows new, then current selection
// - keep running old loop input while new starts
// - suspend system while loop input changes and locks
// - failed loop lock triggers fail-safe monitor
// - sleep mid-switch abandons switch and sleeps
// - wake with hold clear uses new clock, flags
// - wake with hold set keeps old, re-requests
`timescale 1ns/1ps
`default_nettype none
module clock_switch_sequencer #(
   parameter int LOCK_CYCLES = clk_switch_pkg::LOCK_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // new clock request register write
   input wire logic req_write,
   input wire logic [clk_switch_pkg::SRC_W-1:0] req_source,
   input wire logic [clk_switch_pkg::DIV_W-1:0] req_divider,
   input wire logic switch_hold,
   input wire logic int_clear,
   // power state
   input wire logic sleep_enter,
   input wire logic wake,
   // oscillators and loop
   input wire logic osc_ready,
   input wire logic loop_locked,
   output logic osc_enable,
   output logic [clk_switch_pkg::SRC_W-1:0] osc_start_sel,
   output logic [clk_switch_pkg::SRC_W-1:0] loop_input_sel,
   // status
   output logic [clk_switch_pkg::SRC_W-1:0] new_source_sel,
   output logic [clk_switch_pkg::DIV_W-1:0] new_divider,
   output logic [clk_switch_pkg::SRC_W-1:0] current_source_sel,
   output logic [clk_switch_pkg::DIV_W-1:0] current_divider,
   output logic switch_ready_flag,
   output logic new_source_ready_flag,
   output logic switch_done_int_flag,
   output logic system_suspend,
   output logic fail_safe_clock_monitor,
   output logic sleeping
);
   import clk_switch_pkg::*;

   switch_state_t state;
   logic pending;
   logic same_src;
   logic loop_change;
   logic commit;
   logic wake_commit;
   lock_timer_if tmr_bus ();

   lock_timer #(.COUNT(LOCK_CYCLES)) u_lock_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .tmr(tmr_bus.timer)
   );

   // request differs from status; loop input change detection
   assign pending = (new_source_sel != current_source_sel) ||
                    (new_divider != current_divider);
   assign same_src = (new_source_sel == current_source_sel);
   assign loop_change = is_loop(new_source_sel) &&
                        is_loop(current_source_sel) && !same_src;
   assign wake_commit = (state == ST_SLEEP) && wake && !switch_hold &&
                        pending;
   assign commit = wake_commit || (!sleep_enter && !req_write &&
      (((state == ST_READY) && !switch_hold && !loop_change) ||
       ((state == ST_LOCK) && loop_locked)));
   assign tmr_bus.run = (state == ST_LOCK) && !loop_locked;

   // combinational clocking-side controls
   assign osc_enable = (state == ST_WAIT_OSC) || (state == ST_READY) ||
                       (state == ST_LOCK);
   assign osc_start_sel = new_source_sel;
   assign loop_input_sel = (state == ST_LOCK) ? new_source_sel
                                              : current_source_sel;
   assign system_suspend = (state == ST_LOCK);
   assign sleeping = (state == ST_SLEEP);

   // sequencer state
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else if (sleep_enter && state != ST_SLEEP) begin
         state <= ST_SLEEP;
      end else if (req_write && state != ST_SLEEP) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (pending) begin
                  state <= same_src ? ST_READY : ST_WAIT_OSC;
               end
            end
            ST_WAIT_OSC: begin
               if (osc_ready) begin
                  state <= ST_READY;
               end
            end
            ST_READY: begin
               if (!switch_hold) begin
                  state <= loop_change ? ST_LOCK : ST_IDLE;
               end
            end
            ST_LOCK: begin
               if (loop_locked || tmr_bus.expired) begin
                  state <= ST_IDLE;
               end
            end
            ST_SLEEP: begin
               if (wake) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // request register; a failed lock drops the request
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         new_source_sel <= SRC_RESET;
         new_divider <= DIV_RESET;
      end else if (req_write) begin
         new_source_sel <= req_source;
         new_divider <= req_divider;
      end else if (state == ST_LOCK && tmr_bus.expired && !loop_locked) begin
         new_source_sel <= current_source_sel;
         new_divider <= current_divider;
      end
   end

   // status register changes only at the switch instant
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         current_source_sel <= SRC_RESET;
         current_divider <= DIV_RESET;
      end else if (commit) begin
         current_source_sel <= new_source_sel;
         current_divider <= new_divider;
      end
   end

   // ready flags: switch-ready set on switch; new-source-ready cleared on switch; both cleared by a new request
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         switch_ready_flag <= 1'b0;
         new_source_ready_flag <= 1'b0;
      end else begin
         if (commit) begin
            switch_ready_flag <= 1'b1;
         end else if (req_write) begin
            switch_ready_flag <= 1'b0;
         end
         if (commit || sleep_enter || req_write) begin
            new_source_ready_flag <= 1'b0;
         end else if (state == ST_WAIT_OSC && osc_ready) begin
            new_source_ready_flag <= 1'b1;
         end else if (state == ST_IDLE && pending && same_src) begin
            new_source_ready_flag <= 1'b1;
         end
      end
   end

   // switch interrupt flag, set wins over clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         switch_done_int_flag <= 1'b0;
      end else if (commit) begin
         switch_done_int_flag <= 1'b1;
      end else if (int_clear) begin
         switch_done_int_flag <= 1'b0;
      end
   end

   // fail-safe pulse on lock timeout
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fail_safe_clock_monitor <= 1'b0;
      end else begin
         fail_safe_clock_monitor <= (state == ST_LOCK) && tmr_bus.expired &&
            !loop_locked && !sleep_enter && !req_write;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_hold;
      commit && !wake_commit |-> !switch_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("switch under hold");

   property p_status_stable;
      !commit |=> $stable(current_source_sel) && $stable(current_divider);
   endproperty
   a_status_stable: assert property (p_status_stable)
      else $error("status moved without switch");

   property p_load;
      commit |=> current_source_sel == $past(new_source_sel) &&
                 current_divider == $past(new_divider) && switch_ready_flag;
   endproperty
   a_load: assert property (p_load) else $error("switch load wrong");

   property p_nsr_clear;
      commit |=> !new_source_ready_flag;
   endproperty
   a_nsr_clear: assert property (p_nsr_clear)
      else $error("ready flag not cleared");

   property p_div_only;
      state == ST_IDLE && pending && same_src && !sleep_enter && !req_write
      && !switch_hold |=> commit;
   endproperty
   a_div_only: assert property (p_div_only)
      else $error("divider switch waited");

   property p_keep_run;
      state == ST_WAIT_OSC |-> !system_suspend &&
                               loop_input_sel == current_source_sel;
   endproperty
   a_keep_run: assert property (p_keep_run)
      else $error("suspended while starting");

   property p_suspend;
      state == ST_READY && !switch_hold && loop_change && !sleep_enter &&
      !req_write |=> system_suspend && loop_input_sel == new_source_sel;
   endproperty
   a_suspend: assert property (p_suspend) else $error("no suspend");

   property p_fail;
      state == ST_LOCK && tmr_bus.expired && !loop_locked && !sleep_enter &&
      !req_write |=> fail_safe_clock_monitor ##1 !fail_safe_clock_monitor;
   endproperty
   a_fail: assert property (p_fail) else $error("fail-safe missed");

   property p_sleep;
      sleep_enter && state != ST_SLEEP && !commit |=> sleeping &&
      $stable(current_source_sel) && !osc_enable;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not taken");

   property p_wake_new;
      state == ST_SLEEP && wake && !switch_hold && pending |=>
      current_source_sel == $past(new_source_sel) && switch_done_int_flag;
   endproperty
   a_wake_new: assert property (p_wake_new)
      else $error("wake not on new clock");

   property p_wake_old;
      state == ST_SLEEP && wake && switch_hold && pending && !req_write |=>
      $stable(current_source_sel) && state == ST_IDLE ##1 osc_enable ||
      state == ST_READY;
   endproperty
   a_wake_old: assert property (p_wake_old)
      else $error("request not reissued");

   c_div_only: cover property (state == ST_IDLE && pending && same_src
                               ##1 commit);
   c_loop: cover property (state == ST_LOCK ##[1:20] commit);
   c_wake: cover property (wake_commit);
   c_fail: cover property (fail_safe_clock_monitor);
endmodule : clock_switch_sequencer
`default_nettype wire

// File: tb/osc_loop_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the oscillators and the loop, with start-up and lock delays
module osc_loop_model #(
   parameter int START_CYC = 4,
   parameter int LOCK_CYC = 3
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // requests from the sequencer, and no_lock from the test
   input wire logic osc_enable,
   input wire logic system_suspend,
   input wire logic no_lock,
   // readiness back to the sequencer
   output logic osc_ready,
   output logic loop_locked
);
   int start_cnt;
   int lock_cnt;
   // start-up delay counts only while the new source is enabled
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) start_cnt <= 0;
      else if (!osc_enable) start_cnt <= 0;
      else if (start_cnt < START_CYC) start_cnt <= start_cnt + 1;
   end
   // lock delay counts only while the system is suspended
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) lock_cnt <= 0;
      else if (!system_suspend) lock_cnt <= 0;
      else if (lock_cnt < LOCK_CYC) lock_cnt <= lock_cnt + 1;
   end
   // ready drops at once when disabled; a failing loop never locks
   assign osc_ready = osc_enable && (start_cnt == START_CYC);
   assign loop_locked = system_suspend && !no_lock && (lock_cnt == LOCK_CYC);
endmodule : osc_loop_model
`default_nettype wire

// File: tb/tb_clock_switch_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_switch_sequencer;
   import clk_switch_pkg::*;
   logic clock, sys_rst, req_write, switch_hold, int_clear;
   logic sleep_enter, wake, osc_ready, loop_locked, no_lock;
   logic [2:0] req_source, osc_start_sel, loop_input_sel;
   logic [2:0] new_source_sel, current_source_sel;
   logic [3:0] req_divider, new_divider, current_divider;
   logic osc_enable, switch_ready_flag, new_source_ready_flag;
   logic switch_done_int_flag, system_suspend, fail_safe_clock_monitor;
   logic sleeping;
   int n_mismatch = 0;
   int samples_checked = 0;
   // design under test with a short lock timeout
   clock_switch_sequencer #(.LOCK_CYCLES(8)) dut (.clock(clock),
      .sys_rst(sys_rst), .req_write(req_write), .req_source(req_source),
      .req_divider(req_divider), .switch_hold(switch_hold),
      .int_clear(int_clear), .sleep_enter(sleep_enter), .wake(wake),
      .osc_ready(osc_ready), .loop_locked(loop_locked),
      .osc_enable(osc_enable), .osc_start_sel(osc_start_sel),
      .loop_input_sel(loop_input_sel), .new_source_sel(new_source_sel),
      .new_divider(new_divider), .current_source_sel(current_source_sel),
      .current_divider(current_divider),
      .switch_ready_flag(switch_ready_flag),
      .new_source_ready_flag(new_source_ready_flag),
      .switch_done_int_flag(switch_done_int_flag),
      .system_suspend(system_suspend),
      .fail_safe_clock_monitor(fail_safe_clock_monitor),
      .sleeping(sleeping));
   // far side: oscillators and loop
   osc_loop_model osc (.clock(clock), .sys_rst(sys_rst),
      .osc_enable(osc_enable), .system_suspend(system_suspend),
      .no_lock(no_lock), .osc_ready(osc_ready), .loop_locked(loop_locked));
   // clock generator
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   // compare one observed value
   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic go(input int n);
      repeat (n) @(negedge clock);
   endtask : go
   // one write of the new clock request
   task automatic req(input logic [2:0] s, input logic [3:0] d);
      req_source = s;
      req_divider = d;
      req_write = 1'b1;
      go(1);
      req_write = 1'b0;
   endtask : req
   task automatic status(input logic [7:0] exp);
      check("status", exp, {1'b0, current_source_sel, current_divider});
   endtask : status
   // bounded wait for the status to reach a value
   task automatic wait_status(input logic [7:0] exp);
      int i;
      for (i = 0; i < 60; i++) begin
         if ({1'b0, current_source_sel, current_divider} === exp) break;
         go(1);
      end
      status(exp);
      if (i == 60) end_of_test();
   endtask : wait_status
   // bounded wait for suspend (fail low) or the fail-safe pulse (fail high)
   task automatic wait_bit(input string name, input bit fail);
      int i;
      logic v;
      for (i = 0; i < 60; i++) begin
         v = fail ? fail_safe_clock_monitor : system_suspend;
         if (v === 1'b1) break;
         go(1);
      end
      v = fail ? fail_safe_clock_monitor : system_suspend;
      check(name, 8'h01, {7'h00, v});
      if (i == 60) end_of_test();
   endtask : wait_bit
   // pulse helpers for sleep and wake
   task automatic nap;
      sleep_enter = 1'b1;
      go(1);
      sleep_enter = 1'b0;
   endtask : nap
   task automatic rise;
      wake = 1'b1;
      go(1);
      wake = 1'b0;
   endtask : rise
   // main sequence
   initial begin
      {sys_rst, req_write, switch_hold, int_clear} = 4'hf;
      {req_write, switch_hold, int_clear, sleep_enter, wake, no_lock} = 6'h00;
      req_source = 3'h0;
      req_divider = 4'h0;
      go(4);
      sys_rst = 1'b0;
      status(8'h00);
      req(3'h0, 4'h5);
      go(1);
      status(8'h00);
      check("nsready", 8'h01, {7'h00, new_source_ready_flag});
      go(1);
      status(8'h05);
      check("ready", 8'h01, {7'h00, switch_ready_flag});
      check("nsready", 8'h00, {7'h00, new_source_ready_flag});
      switch_hold = 1'b1;
      req(3'h0, 4'h3);
      go(12);
      status(8'h05);
      switch_hold = 1'b0;
      wait_status(8'h03);
      req(SRC_LOOP_HF, 4'h3);
      wait_status(8'h13);
      req(SRC_LOOP_EXT, 4'h3);
      go(2);
      check("suspend", 8'h00, {7'h00, system_suspend});
      check("loopin", 8'h01, {5'h00, loop_input_sel});
      check("oscen", 8'h01, {7'h00, osc_enable});
      check("oscsel", 8'h02, {5'h00, osc_start_sel});
      wait_bit("suspend", 1'b0);
      check("loopin", 8'h02, {5'h00, loop_input_sel});
      status(8'h13);
      wait_status(8'h23);
      no_lock = 1'b1;
      req(SRC_LOOP_HF, 4'h3);
      wait_bit("failsafe", 1'b1);
      go(1);
      status(8'h23);
      check("newreq", 8'h23, {1'b0, new_source_sel, new_divider});
      no_lock = 1'b0;
      int_clear = 1'b1;
      go(1);
      int_clear = 1'b0;
      check("intflag", 8'h00, {7'h00, switch_done_int_flag});
      req(3'h0, 4'h0);
      nap();
      go(6);
      check("sleeping", 8'h01, {7'h00, sleeping});
      check("oscen", 8'h00, {7'h00, osc_enable});
      status(8'h23);
      rise();
      status(8'h00);
      check("intflag", 8'h01, {7'h00, switch_done_int_flag});
      switch_hold = 1'b1;
      req(3'h0, 4'h6);
      nap();
      go(3);
      rise();
      go(2);
      status(8'h00);
      check("sleeping", 8'h00, {7'h00, sleeping});
      switch_hold = 1'b0;
      wait_status(8'h06);
      req(3'h0, 4'h6);
      go(4);
      check("nsready", 8'h00, {7'h00, new_source_ready_flag});
      status(8'h06);
      end_of_test();
   end
   // cut a hang short
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_of_test();
   end
endmodule : tb_clock_switch_sequencer
`default_nettype wire
